/* design/sfcp_defines.vh */
// Purpose: shared constants of the serial flash command and protect logic
// Assumes: included by the top design file of the block only
// Notes:   times in their own unit, cycle counts derived in the top module
`ifndef SFCP_DEFINES_VH
`define SFCP_DEFINES_VH
// ****************************************
// opcodes
// ****************************************
`define SFCP_OP_WREN     8'h06
`define SFCP_OP_WRDI     8'h04
`define SFCP_OP_PDN      8'hB9
`define SFCP_OP_RID      8'hAB
`define SFCP_OP_JID      8'h9F
`define SFCP_OP_SSE_A    8'hD7
`define SFCP_OP_SSE_B    8'h20
`define SFCP_OP_SE       8'hD8
`define SFCP_OP_CE       8'hC7
`define SFCP_OP_PP       8'h02
`define SFCP_OP_RDSR     8'h05
`define SFCP_OP_WRSR     8'h01
// ****************************************
// status layout and reset values
// ****************************************
`define SFCP_ST_BUSY     0
`define SFCP_ST_WEL      1
`define SFCP_ST_PL_LO    2
`define SFCP_ST_PL_HI    4
`define SFCP_ST_LOCK     7
`define SFCP_PL_RST      3'h0
`define SFCP_LOCK_RST    1'h0
// ****************************************
// protected region bases
// ****************************************
`define SFCP_BASE_L1     20'hF_0000
`define SFCP_BASE_L2     20'hE_0000
`define SFCP_BASE_L3     20'hC_0000
`define SFCP_BASE_L4     20'h8_0000
// ****************************************
// erase sizes and write kinds
// ****************************************
`define SFCP_ER_4K       2'h0
`define SFCP_ER_64K      2'h1
`define SFCP_ER_CHIP     2'h2
`define SFCP_WK_NONE     2'h0
`define SFCP_WK_ERASE    2'h1
`define SFCP_WK_PROG     2'h2
`define SFCP_WK_STAT     2'h3
// ****************************************
// timing
// ****************************************
`define SFCP_CLK_MHZ     100
`define SFCP_T_SSE_US    80000
`define SFCP_T_SE_US     100000
`define SFCP_T_CE_US     250000
`define SFCP_T_PP_US     300
`define SFCP_T_SRW_US    10000
`endif

/* design/sfcp_sync.v */
// Purpose: three-stage synchroniser with edge pulses
// Assumes: d_in is asynchronous to clk_in
// Notes:   a change counts once stages two and three agree
`timescale 1ns/1ns
module sfcp_sync #(
	parameter [0:0] INIT = 1'b1
) (
	input  wire clk_in,
	input  wire rst_n_in,
	input  wire d_in,
	output wire lvl_out,
	output wire rise_out,
	output wire fall_out
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;
	reg lvl_reg;
	wire agree = (s2_reg == s3_reg);
	assign lvl_out  = lvl_reg;
	assign rise_out = agree & s3_reg & ~lvl_reg;
	assign fall_out = agree & ~s3_reg & lvl_reg;
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s1_reg  <= INIT;
			s2_reg  <= INIT;
			s3_reg  <= INIT;
			lvl_reg <= INIT;
		end else begin
			s1_reg <= d_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (agree)
				lvl_reg <= s3_reg;
		end
	end
endmodule

/* design/sfcp_timer.v */
// Purpose: self-timed write duration counter
// Assumes: start_in is a one-cycle pulse while idle
// Notes:   done_out pulses one cycle as busy_out falls
`timescale 1ns/1ns
module sfcp_timer #(
	parameter WIDTH = 25
) (
	input  wire             clk_in,
	input  wire             rst_n_in,
	input  wire             start_in,
	input  wire [WIDTH-1:0] load_in,
	output reg              busy_out,
	output reg              done_out
);
	reg [WIDTH-1:0] cnt_reg;
	localparam [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_reg  <= {WIDTH{1'b0}};
			busy_out <= 1'b0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (start_in) begin
				cnt_reg  <= load_in;
				busy_out <= 1'b1;
			end else if (busy_out) begin
				if (cnt_reg <= ONE) begin
					busy_out <= 1'b0;
					done_out <= 1'b1;
				end
				cnt_reg <= cnt_reg - ONE;
			end
		end
	end
endmodule

/* design/sfcp_top.v */
// Purpose: command, protect and write sequencing of an 8 Mbit serial flash
// Assumes: SPI mode 0 or 3, SCK much slower than CORE_CLK_IN
// Notes:   array access leaves through the MEM_* ports
//
// What this block does
// - protect level picks the protected top region
// - chip erase only at protect level zero
// - lock bit and low pin block status write
// - opcode 06h sets write enable latch
// - opcode 04h clears write enable latch
// - B9h enters power-down unless busy
// - ABh byte or reset leaves power-down
// - D7h/20h erases 4 KB block A19-A12
// - erase starts at select rise, timer ends
// - D8h erases 64 KB block A19-A16
// - C7h erases whole array
// - 02h programs bytes within one page
// - over 256 bytes keeps last 256
// - program only on whole data bytes
// - 9Fh streams maker then device code
// - ABh ID starts fifth byte by A0
// - ID reads rejected while busy
// - pause pin freezes link, output released
// - write commands need byte-aligned select rise
// - busy bit high while write runs
// - latch clears at reset and write end
`timescale 1ns/1ns
`include "sfcp_defines.vh"
module sfcp_top #(
	parameter [24:0] SSE_CYCLES = `SFCP_T_SSE_US * `SFCP_CLK_MHZ,
	parameter [24:0] SE_CYCLES  = `SFCP_T_SE_US * `SFCP_CLK_MHZ,
	parameter [24:0] CE_CYCLES  = `SFCP_T_CE_US * `SFCP_CLK_MHZ,
	parameter [24:0] PP_CYCLES  = `SFCP_T_PP_US * `SFCP_CLK_MHZ,
	parameter [24:0] SRW_CYCLES = `SFCP_T_SRW_US * `SFCP_CLK_MHZ,
	parameter [7:0]  MAKER_ID   = 8'hA5, // arbitrary value
	parameter [7:0]  DEVICE_ID  = 8'h5A  // arbitrary value
) (
	input  wire        CORE_CLK_IN,
	input  wire        RSTN_IN,
	input  wire        CS_N_IN,
	input  wire        SCK_IN,
	input  wire        SI_IN,
	input  wire        WP_N_IN,
	input  wire        PAUSE_N_IN,
	output reg         SO_OUT,
	output reg         SO_OE_OUT,
	output reg         POWER_DOWN_OUT,
	output reg         BUSY_OUT,
	output reg         MEM_ERASE_OUT,
	output reg  [1:0]  MEM_ERASE_SIZE_OUT,
	output reg  [19:0] MEM_ADDR_OUT,
	output reg         MEM_WR_OUT,
	output reg  [7:0]  MEM_DATA_OUT
);
// ****************************************
// reset release and input sampling
// ****************************************
	reg rst_a_reg;
	reg rst_n_reg;
	always @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			rst_a_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_a_reg <= 1'b1;
			rst_n_reg <= rst_a_reg;
		end
	end

	wire cs_n_lvl;
	wire cs_fall;
	wire cs_rise;
	wire sck_lvl;
	wire sck_rise;
	wire sck_fall;
	wire si_lvl;
	wire wp_n_lvl;
	wire pause_rise;
	wire pause_fall;
	sfcp_sync #(.INIT(1'b1)) u_cs (.clk_in(CORE_CLK_IN), .rst_n_in(rst_n_reg), .d_in(CS_N_IN),
		.lvl_out(cs_n_lvl), .rise_out(cs_rise), .fall_out(cs_fall));
	sfcp_sync #(.INIT(1'b0)) u_sck (.clk_in(CORE_CLK_IN), .rst_n_in(rst_n_reg), .d_in(SCK_IN),
		.lvl_out(sck_lvl), .rise_out(sck_rise), .fall_out(sck_fall));
	sfcp_sync #(.INIT(1'b0)) u_si (.clk_in(CORE_CLK_IN), .rst_n_in(rst_n_reg), .d_in(SI_IN),
		.lvl_out(si_lvl), .rise_out(), .fall_out());
	sfcp_sync #(.INIT(1'b0)) u_wp (.clk_in(CORE_CLK_IN), .rst_n_in(rst_n_reg), .d_in(WP_N_IN),
		.lvl_out(wp_n_lvl), .rise_out(), .fall_out());
	sfcp_sync #(.INIT(1'b1)) u_pause (.clk_in(CORE_CLK_IN), .rst_n_in(rst_n_reg), .d_in(PAUSE_N_IN),
		.lvl_out(), .rise_out(pause_rise), .fall_out(pause_fall));

// ****************************************
// write timer
// ****************************************
	reg         tmr_start_reg;
	reg  [24:0] tmr_load_reg;
	wire        busy;
	wire        done;
	sfcp_timer #(.WIDTH(25)) u_tmr (.clk_in(CORE_CLK_IN), .rst_n_in(rst_n_reg), .start_in(tmr_start_reg),
		.load_in(tmr_load_reg), .busy_out(busy), .done_out(done));

// ****************************************
// state
// ****************************************
	reg  [7:0]  shift_reg;
	reg  [2:0]  bit_cnt_reg;
	reg  [2:0]  byte_cnt_reg;
	reg  [7:0]  opcode_reg;
	reg         live_reg;
	reg  [23:0] addr_reg;
	reg  [7:0]  col_reg;
	reg  [8:0]  data_cnt_reg;
	reg  [7:0]  page_mem [0:255];
	reg         paused_reg;
	reg         wel_reg;
	reg  [2:0]  level_reg;
	reg         lock_reg;
	reg  [2:0]  pend_level_reg;
	reg         pend_lock_reg;
	reg  [1:0]  kind_reg;
	reg  [8:0]  left_reg;
	reg  [7:0]  pcol_reg;
	reg  [11:0] ppage_reg;
	reg  [7:0]  tx_reg;
	reg         tx_en_reg;
	reg         tx_alt_reg;

	wire        edge_ok   = ~cs_n_lvl & ~paused_reg;
	wire        byte_done = sck_rise & edge_ok & (bit_cnt_reg == 3'h7);
	wire [7:0]  byte_in   = {shift_reg[6:0], si_lvl};
	wire [7:0]  status    = {lock_reg, 2'b00, level_reg, wel_reg, busy};
	wire        aligned   = (bit_cnt_reg == 3'h0);
	wire        may_write = aligned & live_reg & wel_reg & ~busy;

	// protected when the block base falls in the selected top region
	function prot_hit;
		input [2:0]  lvl;
		input [19:0] a;
		begin
			case (lvl)
				3'h0: prot_hit = 1'b0;
				3'h1: prot_hit = (a >= `SFCP_BASE_L1);
				3'h2: prot_hit = (a >= `SFCP_BASE_L2);
				3'h3: prot_hit = (a >= `SFCP_BASE_L3);
				3'h4: prot_hit = (a >= `SFCP_BASE_L4);
				default: prot_hit = 1'b1;
			endcase
		end
	endfunction

// ****************************************
// serial engine and write sequencing
// ****************************************
	always @(posedge CORE_CLK_IN) begin
		if (byte_done && byte_cnt_reg >= 3'h4 && opcode_reg == `SFCP_OP_PP && live_reg && !busy)
			page_mem[col_reg] <= byte_in;
	end

	always @(posedge CORE_CLK_IN or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			shift_reg      <= 8'h00;
			bit_cnt_reg    <= 3'h0;
			byte_cnt_reg   <= 3'h0;
			opcode_reg     <= 8'h00;
			live_reg       <= 1'b0;
			addr_reg       <= 24'h00_0000;
			col_reg        <= 8'h00;
			data_cnt_reg   <= 9'h000;
			paused_reg     <= 1'b0;
			wel_reg        <= 1'b0;
			level_reg      <= `SFCP_PL_RST;
			lock_reg       <= `SFCP_LOCK_RST;
			pend_level_reg <= 3'h0;
			pend_lock_reg  <= 1'b0;
			kind_reg       <= `SFCP_WK_NONE;
			left_reg       <= 9'h000;
			pcol_reg       <= 8'h00;
			ppage_reg      <= 12'h000;
			tx_reg         <= 8'h00;
			tx_en_reg      <= 1'b0;
			tx_alt_reg     <= 1'b0;
			tmr_start_reg  <= 1'b0;
			tmr_load_reg   <= 25'h000_0000;
			POWER_DOWN_OUT <= 1'b0;
			MEM_ERASE_OUT  <= 1'b0;
			MEM_ERASE_SIZE_OUT <= `SFCP_ER_4K;
			MEM_ADDR_OUT   <= 20'h0_0000;
			MEM_WR_OUT     <= 1'b0;
			MEM_DATA_OUT   <= 8'h00;
			SO_OUT         <= 1'b0;
			SO_OE_OUT      <= 1'b0;
			BUSY_OUT       <= 1'b0;
		end else begin
			tmr_start_reg <= 1'b0;
			MEM_ERASE_OUT <= 1'b0;
			MEM_WR_OUT    <= 1'b0;
			BUSY_OUT      <= busy | tmr_start_reg;
			SO_OE_OUT     <= tx_en_reg & edge_ok;
			// pause entry with SCK low, exit on pin rise or select rise
			if (pause_fall && !cs_n_lvl && !sck_lvl)
				paused_reg <= 1'b1;
			else if (pause_rise || cs_rise)
				paused_reg <= 1'b0;

			if (cs_fall) begin
				bit_cnt_reg  <= 3'h0;
				byte_cnt_reg <= 3'h0;
				data_cnt_reg <= 9'h000;
				tx_en_reg    <= 1'b0;
			end

			if (sck_rise && edge_ok) begin
				shift_reg   <= byte_in;
				bit_cnt_reg <= bit_cnt_reg + 3'h1;
			end

			if (sck_fall && edge_ok && tx_en_reg) begin
				SO_OUT <= tx_reg[7];
				tx_reg <= {tx_reg[6:0], 1'b0};
			end

			if (byte_done) begin
				if (byte_cnt_reg != 3'h5)
					byte_cnt_reg <= byte_cnt_reg + 3'h1;
				if (byte_cnt_reg == 3'h0) begin
					opcode_reg <= byte_in;
					// in power-down only ID reads pass
					live_reg <= ~POWER_DOWN_OUT | (byte_in == `SFCP_OP_RID) | (byte_in == `SFCP_OP_JID);
					if (byte_in == `SFCP_OP_RID)
						POWER_DOWN_OUT <= 1'b0;
					if (byte_in == `SFCP_OP_RDSR && !POWER_DOWN_OUT) begin
						tx_reg    <= status;
						tx_en_reg <= 1'b1;
					end
					if (byte_in == `SFCP_OP_JID && !busy) begin
						tx_reg     <= MAKER_ID;
						tx_alt_reg <= 1'b1;
						tx_en_reg  <= 1'b1;
					end
				end else if (byte_cnt_reg <= 3'h3) begin
					addr_reg <= {addr_reg[15:0], byte_in};
					if (byte_cnt_reg == 3'h1 && opcode_reg == `SFCP_OP_WRSR && !busy) begin
						pend_level_reg <= byte_in[`SFCP_ST_PL_HI:`SFCP_ST_PL_LO];
						pend_lock_reg  <= byte_in[`SFCP_ST_LOCK];
					end
					if (byte_cnt_reg == 3'h3) begin
						col_reg <= byte_in;
						if (opcode_reg == `SFCP_OP_RID && live_reg && !busy) begin
							tx_reg     <= byte_in[0] ? DEVICE_ID : MAKER_ID;
							tx_alt_reg <= ~byte_in[0];
							tx_en_reg  <= 1'b1;
						end
					end
				end else if (opcode_reg == `SFCP_OP_PP) begin
					col_reg <= col_reg + 8'h01;
					if (data_cnt_reg != 9'h100)
						data_cnt_reg <= data_cnt_reg + 9'h001;
				end
				if (tx_en_reg) begin
					if (opcode_reg == `SFCP_OP_RDSR)
						tx_reg <= status;
					else begin
						tx_reg     <= tx_alt_reg ? DEVICE_ID : MAKER_ID;
						tx_alt_reg <= ~tx_alt_reg;
					end
				end
			end

			// write end first, so a write-enable at the same edge wins
			if (done) begin
				wel_reg  <= 1'b0;
				kind_reg <= `SFCP_WK_NONE;
				if (kind_reg == `SFCP_WK_STAT) begin
					level_reg <= pend_level_reg;
					lock_reg  <= pend_lock_reg;
				end
			end

			if (cs_rise) begin
				tx_en_reg <= 1'b0;
				if (aligned && live_reg && byte_cnt_reg == 3'h1 && opcode_reg == `SFCP_OP_WREN)
					wel_reg <= 1'b1;
				if (aligned && live_reg && byte_cnt_reg == 3'h1 && opcode_reg == `SFCP_OP_WRDI)
					wel_reg <= 1'b0;
				if (aligned && byte_cnt_reg == 3'h1 && opcode_reg == `SFCP_OP_PDN && !busy)
					POWER_DOWN_OUT <= 1'b1;
				if (may_write) begin
					if (opcode_reg == `SFCP_OP_WRSR && byte_cnt_reg == 3'h2 && (wp_n_lvl || !lock_reg)) begin
						kind_reg      <= `SFCP_WK_STAT;
						tmr_load_reg  <= SRW_CYCLES;
						tmr_start_reg <= 1'b1;
					end
					if ((opcode_reg == `SFCP_OP_SSE_A || opcode_reg == `SFCP_OP_SSE_B) && byte_cnt_reg == 3'h4
						&& !prot_hit(level_reg, {addr_reg[19:12], 12'h000})) begin
						kind_reg           <= `SFCP_WK_ERASE;
						MEM_ERASE_OUT      <= 1'b1;
						MEM_ERASE_SIZE_OUT <= `SFCP_ER_4K;
						MEM_ADDR_OUT       <= {addr_reg[19:12], 12'h000};
						tmr_load_reg       <= SSE_CYCLES;
						tmr_start_reg      <= 1'b1;
					end
					if (opcode_reg == `SFCP_OP_SE && byte_cnt_reg == 3'h4
						&& !prot_hit(level_reg, {addr_reg[19:16], 16'h0000})) begin
						kind_reg           <= `SFCP_WK_ERASE;
						MEM_ERASE_OUT      <= 1'b1;
						MEM_ERASE_SIZE_OUT <= `SFCP_ER_64K;
						MEM_ADDR_OUT       <= {addr_reg[19:16], 16'h0000};
						tmr_load_reg       <= SE_CYCLES;
						tmr_start_reg      <= 1'b1;
					end
					if (opcode_reg == `SFCP_OP_CE && byte_cnt_reg == 3'h1 && level_reg == 3'h0) begin
						kind_reg           <= `SFCP_WK_ERASE;
						MEM_ERASE_OUT      <= 1'b1;
						MEM_ERASE_SIZE_OUT <= `SFCP_ER_CHIP;
						MEM_ADDR_OUT       <= 20'h0_0000;
						tmr_load_reg       <= CE_CYCLES;
						tmr_start_reg      <= 1'b1;
					end
					// whole data bytes only, at least one
					if (opcode_reg == `SFCP_OP_PP && byte_cnt_reg == 3'h5
						&& !prot_hit(level_reg, {addr_reg[19:8], 8'h00})) begin
						kind_reg      <= `SFCP_WK_PROG;
						ppage_reg     <= addr_reg[19:8];
						left_reg      <= data_cnt_reg;
						pcol_reg      <= data_cnt_reg[8] ? col_reg : addr_reg[7:0];
						tmr_load_reg  <= PP_CYCLES;
						tmr_start_reg <= 1'b1;
					end
				end
			end

			// stream the page buffer out while the program runs
			if (kind_reg == `SFCP_WK_PROG && left_reg != 9'h000) begin
				MEM_WR_OUT   <= 1'b1;
				MEM_ADDR_OUT <= {ppage_reg, pcol_reg};
				MEM_DATA_OUT <= page_mem[pcol_reg];
				pcol_reg     <= pcol_reg + 8'h01;
				left_reg     <= left_reg - 9'h001;
			end
		end
	end
endmodule

/* test/sfcp_props.sv */
// Purpose: port-level assertions of the flash command logic
// Assumes: bound to sfcp_top, one clock domain
// Notes:   windows allow for the input synchronisers
`timescale 1ns/1ns
module sfcp_props (
	input wire        CORE_CLK_IN,
	input wire        RSTN_IN,
	input wire        CS_N_IN,
	input wire        PAUSE_N_IN,
	input wire        SO_OE_OUT,
	input wire        POWER_DOWN_OUT,
	input wire        BUSY_OUT,
	input wire        MEM_ERASE_OUT,
	input wire [1:0]  MEM_ERASE_SIZE_OUT,
	input wire [19:0] MEM_ADDR_OUT,
	input wire        MEM_WR_OUT
);
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RSTN_IN);
	// ****************************************
	// sequences
	// ****************************************
	sequence s_desel; CS_N_IN [*8]; endsequence
	sequence s_paused; (!CS_N_IN && !PAUSE_N_IN) [*8]; endsequence
	sequence s_run; !BUSY_OUT ##1 BUSY_OUT [*8]; endsequence
	erase_busy_a: assert property (MEM_ERASE_OUT |-> s_run)
		else $error("erase pulse not followed by busy");
	prog_busy_a: assert property (MEM_WR_OUT |-> BUSY_OUT)
		else $error("program pulse outside busy");
	desel_quiet_a: assert property (s_desel |-> !SO_OE_OUT)
		else $error("serial output driven while deselected");
	pause_quiet_a: assert property (s_paused |-> !SO_OE_OUT)
		else $error("serial output driven while paused");
	pd_no_write_a: assert property (POWER_DOWN_OUT |-> !MEM_ERASE_OUT && !MEM_WR_OUT)
		else $error("array write in power-down");
	pd_entry_a: assert property ($rose(POWER_DOWN_OUT) |-> !BUSY_OUT)
		else $error("power-down entered while busy");
	small_align_a: assert property (MEM_ERASE_OUT && MEM_ERASE_SIZE_OUT == 2'h0 |-> MEM_ADDR_OUT[11:0] == 12'h000)
		else $error("small erase base not 4K aligned");
	sect_align_a: assert property (MEM_ERASE_OUT && MEM_ERASE_SIZE_OUT == 2'h1 |-> MEM_ADDR_OUT[15:0] == 16'h0000)
		else $error("sector erase base not 64K aligned");
endmodule
bind sfcp_top sfcp_props u_props (.CORE_CLK_IN(CORE_CLK_IN), .RSTN_IN(RSTN_IN), .CS_N_IN(CS_N_IN),
	.PAUSE_N_IN(PAUSE_N_IN), .SO_OE_OUT(SO_OE_OUT), .POWER_DOWN_OUT(POWER_DOWN_OUT), .BUSY_OUT(BUSY_OUT),
	.MEM_ERASE_OUT(MEM_ERASE_OUT), .MEM_ERASE_SIZE_OUT(MEM_ERASE_SIZE_OUT), .MEM_ADDR_OUT(MEM_ADDR_OUT),
	.MEM_WR_OUT(MEM_WR_OUT));

/* test/sfcp_host.sv */
// Purpose: SPI mode 0 host driving the flash link
// Assumes: signals change on the falling core clock edge
// Notes:   one SCK half period is HALF core clocks
`timescale 1ns/1ns
module sfcp_host #(
	parameter HALF = 8
) (
	input  wire clk_in,
	input  wire so_in,
	output reg  cs_n_out,
	output reg  sck_out,
	output reg  si_out,
	output reg  pause_n_out
);
	initial begin
		cs_n_out    = 1'b1;
		sck_out     = 1'b0;
		si_out      = 1'b0;
		pause_n_out = 1'b1;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic frame_open();
		wait_clk(2);
		cs_n_out = 1'b0;
		wait_clk(HALF);
	endtask
	// released data line shows no stale value
	task automatic frame_close();
		wait_clk(HALF);
		cs_n_out = 1'b1;
		si_out   = ~si_out;
		wait_clk(2 * HALF);
	endtask
	// msb first; so is taken late in the low phase
	task automatic xbits(input int n, input logic [7:0] tx, output logic [7:0] rx);
		int i;
		rx = 8'h00;
		for (i = 0; i < n; i++) begin
			si_out = tx[7-i];
			wait_clk(HALF);
			rx = {rx[6:0], so_in};
			sck_out = 1'b1;
			wait_clk(HALF);
			sck_out = 1'b0;
		end
	endtask
endmodule

/* test/tb_top.sv */
// Purpose: self-checking bench of the flash command logic
// Assumes: write times shortened by parameters
// Notes:   array writes are captured from the MEM ports
`timescale 1ns/1ns
module tb_top;
	typedef struct packed {logic [7:0] op; logic [23:0] adr; logic [1:0] sz; logic [19:0] base;} sfcp_row_t;
	sfcp_row_t   rows [3] = '{'{8'h20, 24'h01_2345, 2'h0, 20'h1_2000}, '{8'hD7, 24'hF0_4ABC, 2'h0, 20'h0_4000},
	                          '{8'hD8, 24'h05_ABCD, 2'h1, 20'h5_0000}};
	logic        clk = 1'b0;
	logic        rstn;
	logic        wp_n;
	wire         cs_n, sck, si, pause_n, so, so_oe, pdn, busy, er, wr;
	wire  [1:0]  er_sz;
	wire  [19:0] adr;
	wire  [7:0]  wdat;
	logic [19:0] er_cnt = 20'h0_0000, wr_cnt = 20'h0_0000, n0, er_adr, wr_pg;
	logic [1:0]  er_size;
	logic [7:0]  col [256];
	logic [7:0]  rx, got [2];
	int          fails = 0, cmp_count = 0, cyc = 0, k;
	always #5 clk = ~clk;
	sfcp_top #(.SSE_CYCLES(25'd600), .SE_CYCLES(25'd700), .CE_CYCLES(25'd800), .PP_CYCLES(25'd600),
		.SRW_CYCLES(25'd500)) dut (.CORE_CLK_IN(clk), .RSTN_IN(rstn), .CS_N_IN(cs_n), .SCK_IN(sck),
		.SI_IN(si), .WP_N_IN(wp_n), .PAUSE_N_IN(pause_n), .SO_OUT(so), .SO_OE_OUT(so_oe),
		.POWER_DOWN_OUT(pdn), .BUSY_OUT(busy), .MEM_ERASE_OUT(er), .MEM_ERASE_SIZE_OUT(er_sz),
		.MEM_ADDR_OUT(adr), .MEM_WR_OUT(wr), .MEM_DATA_OUT(wdat));
	sfcp_host host (.clk_in(clk), .so_in(so), .cs_n_out(cs_n), .sck_out(sck), .si_out(si), .pause_n_out(pause_n));
	// ****************************************
	// monitors and helpers
	// ****************************************
	always @(posedge clk) begin
		if (er === 1'b1) begin
			er_cnt  <= er_cnt + 20'h0_0001;
			er_size <= er_sz;
			er_adr  <= adr;
		end
		if (wr === 1'b1) begin
			wr_cnt        <= wr_cnt + 20'h0_0001;
			col[adr[7:0]] <= wdat;
			wr_pg         <= adr[19:8];
		end
		cyc++;
		if (cyc == 90000) begin
			fails++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic send(input int nb, input logic [31:0] w, input int nr);
		host.frame_open();
		for (k = 0; k < nb; k++) host.xbits(8, w[31-8*k -: 8], rx);
		for (k = 0; k < nr; k++) begin
			host.xbits(8, 8'h00, rx);
			got[k] = rx;
		end
		host.frame_close();
	endtask
	task automatic wait_idle();
		int t;
		for (t = 0; t < 3000 && busy !== 1'b0; t++) @(negedge clk);
		chk("busy end", 20'h0_0000, {19'h0_0000, busy});
	endtask
	task automatic status(input logic [7:0] e);
		send(1, 32'h0500_0000, 2);
		chk("status", {12'h000, e}, {12'h000, got[1]});
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rstn = 1'b0;
		wp_n = 1'b1;
		repeat (10) @(posedge clk);
		@(negedge clk) rstn = 1'b1;
		repeat (8) @(negedge clk);
		status(8'h00);
		foreach (rows[i]) begin
			n0 = er_cnt;
			send(1, 32'h0600_0000, 0);
			send(4, {rows[i].op, rows[i].adr}, 0);
			status(8'h03);
			wait_idle();
			chk("erase count", n0 + 20'h0_0001, er_cnt);
			chk("erase size", {18'h0_0000, rows[i].sz}, {18'h0_0000, er_size});
			chk("erase base", rows[i].base, er_adr);
			status(8'h00);
		end
		send(1, 32'h0600_0000, 0);
		status(8'h02);
		send(1, 32'h0400_0000, 0);
		status(8'h00);
		n0 = er_cnt;
		send(4, 32'h2001_2000, 0);
		send(1, 32'h0600_0000, 0);
		host.frame_open();
		for (k = 0; k < 3; k++) host.xbits(8, 8'h20, rx);
		host.xbits(7, 8'h00, rx);
		host.frame_close();
		status(8'h02);
		chk("refused erase", n0, er_cnt);
		send(2, 32'h0184_0000, 0);
		status(8'h03);
		wait_idle();
		status(8'h84);
		wp_n = 1'b0;
		send(1, 32'h0600_0000, 0);
		send(2, 32'h0100_0000, 0);
		status(8'h86);
		send(4, 32'h200F_0000, 0);
		status(8'h86);
		chk("protected erase", n0, er_cnt);
		send(4, 32'h200E_F000, 0);
		wait_idle();
		chk("open erase", 20'hE_F000, er_adr);
		send(1, 32'h0600_0000, 0);
		send(1, 32'hC700_0000, 0);
		status(8'h86);
		chk("chip erase refused", n0 + 20'h0_0001, er_cnt);
		wp_n = 1'b1;
		send(2, 32'h0100_0000, 0);
		wait_idle();
		send(1, 32'h0600_0000, 0);
		send(1, 32'hC700_0000, 0);
		wait_idle();
		chk("chip erase", 20'h0_0002, {18'h0_0000, er_size});
		n0 = wr_cnt;
		send(1, 32'h0600_0000, 0);
		send(4, 32'h0201_23FE, 0);
		send(1, 32'h0600_0000, 0);
		host.frame_open();
		host.xbits(8, 8'h02, rx);
		host.xbits(8, 8'h01, rx);
		host.xbits(8, 8'h23, rx);
		host.xbits(8, 8'hFE, rx);
		host.xbits(8, 8'h11, rx);
		host.xbits(8, 8'h22, rx);
		host.xbits(8, 8'h33, rx);
		host.frame_close();
		wait_idle();
		chk("prog count", n0 + 20'h0_0003, wr_cnt);
		chk("prog wrap", 20'h0_0033, {12'h000, col[0]});
		chk("prog page", 20'h0_0123, {8'h00, wr_pg});
		n0 = wr_cnt;
		send(1, 32'h0600_0000, 0);
		host.frame_open();
		host.xbits(8, 8'h02, rx);
		for (k = 0; k < 4; k++) host.xbits(8, 8'h45, rx);
		host.xbits(4, 8'h00, rx);
		host.frame_close();
		status(8'h02);
		chk("partial prog", n0, wr_cnt);
		host.frame_open();
		host.xbits(8, 8'h02, rx);
		host.xbits(8, 8'h00, rx);
		host.xbits(8, 8'h45, rx);
		host.xbits(8, 8'h00, rx);
		for (k = 0; k < 258; k++) host.xbits(8, (k < 256) ? k[7:0] : 8'hEE, rx);
		host.frame_close();
		wait_idle();
		chk("long count", n0 + 20'h0_0100, wr_cnt);
		chk("long col1", 20'h0_00EE, {12'h000, col[1]});
		chk("long col2", 20'h0_0002, {12'h000, col[2]});
		send(1, 32'h9F00_0000, 2);
		chk("jedec id", 20'h0_A55A, {4'h0, got[0], got[1]});
		send(4, 32'hAB00_0001, 2);
		chk("short id", 20'h0_5AA5, {4'h0, got[0], got[1]});
		host.frame_open();
		host.xbits(8, 8'h9F, rx);
		host.wait_clk(4);
		host.pause_n_out = 1'b0;
		host.wait_clk(12);
		chk("paused oe", 20'h0_0000, {19'h0_0000, so_oe});
		host.pause_n_out = 1'b1;
		host.wait_clk(8);
		host.xbits(8, 8'h00, rx);
		host.frame_close();
		chk("resumed id", 20'h0_00A5, {12'h000, rx});
		send(1, 32'h0600_0000, 0);
		send(4, 32'h2001_2000, 0);
		send(1, 32'hB900_0000, 0);
		chk("pd while busy", 20'h0_0000, {19'h0_0000, pdn});
		host.frame_open();
		host.xbits(8, 8'h9F, rx);
		host.xbits(8, 8'h00, rx);
		chk("id oe busy", 20'h0_0000, {19'h0_0000, so_oe});
		host.frame_close();
		wait_idle();
		send(1, 32'hB900_0000, 0);
		chk("pd entry", 20'h0_0001, {19'h0_0000, pdn});
		send(1, 32'h0600_0000, 0);
		send(1, 32'hAB00_0000, 0);
		chk("pd exit", 20'h0_0000, {19'h0_0000, pdn});
		status(8'h00);
		send(1, 32'h0600_0000, 0);
		send(1, 32'hB900_0000, 0);
		rstn = 1'b0;
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		repeat (8) @(negedge clk);
		chk("reset pd", 20'h0_0000, {19'h0_0000, pdn});
		status(8'h00);
		tally_and_finish();
	end
endmodule
